// File: logic/dcsw_top.v
`timescale 1ns/1ps
`default_nettype none
`include "dcsw_map.vh"
// control/status word bank between fieldbus and sequencer
module dcsw_top (
  input  wire        clock_in,              // 200 MHz drive clock
  input  wire        sys_rst_in,            // synchronous, active high
  // register port
  input  wire [3:0]  reg_addr_in,           // word address
  input  wire [15:0] reg_wdata_in,          // write data
  input  wire        reg_wr_in,             // write strobe
  input  wire        reg_rd_in,             // read strobe
  output reg  [15:0] reg_rdata_out,         // read data, next cycle
  // local terminal pins, asynchronous
  input  wire        local_forward_run_request_in,      // local forward run
  input  wire        local_reverse_run_request_in,      // local reverse run
  input  wire        local_not_coast_n_in,  // local coast stop, low = stop
  input  wire        local_not_fast_n_in,   // local fast stop, low = stop
  input  wire        local_permit_in,       // local power-stage permit
  input  wire        local_fault_clear_in,  // local trip reset
  // sequencer and drive conditions, same clock
  input  wire        seq_permit_in,         // switch-on permitted
  input  wire        seq_energised_in,      // switched on
  input  wire        seq_operating_in,      // operating
  input  wire        seq_tripped_in,        // tripped
  input  wire        seq_inhibited_in,      // start-inhibited state
  input  wire        ramp_active_in,        // reference ramp moving
  input  wire        vector_mode_in,        // 1 vector, 0 volts/hertz
  input  wire        torque_limit_in,       // speed loop at torque limit
  input  wire        current_limit_in,      // open-loop current limit
  // sequencer command inputs
  output reg         forward_run_request_out, // run forward
  output reg         reverse_run_request_out, // run reverse
  output reg         stop_request_out,        // not-stop request
  output reg         coast_release_out,       // coast stop released
  output reg         fast_release_out,        // fast stop released
  output reg         drive_enable_out,        // power permit
  output reg         remote_fault_clear_out,  // trip reset level
  // mode view
  output wire        remote_mode_out        // remote comms mode active
);
  localparam NPIN = 6; // synchronised local pins

  reg  [15:0] remote_control_word; // last value written by controller
  reg  [1:0]  mode_reg;            // remote mode and bus select
  wire [15:0] remote_status_word;  // built status
  wire [NPIN-1:0] pins_sync;       // synchronised local pins
  wire        remote_mode;         // remote sequencing active
  wire        bus_sel;             // fieldbus select setting
  wire        loc_fwd;             // local forward
  wire        loc_rev;             // local reverse
  wire        loc_coast;           // local not-coast
  wire        loc_fast;            // local not-fast
  wire        loc_permit;          // local permit
  wire        loc_clr;             // local trip reset
  reg         view_coast;          // coast view for status
  reg         view_fast;           // fast view for status
  wire        limit_hit;           // internal limit

  // local pins cross into the clock domain first
  dcsw_sync2 #(
    .WIDTH (NPIN)
  ) u_sync (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({local_fault_clear_in, local_permit_in, local_not_fast_n_in,
                  local_not_coast_n_in, local_reverse_run_request_in, local_forward_run_request_in}),
    .sync_out   (pins_sync)
  );

  assign loc_fwd    = pins_sync[0];
  assign loc_rev    = pins_sync[1];
  assign loc_coast  = pins_sync[2];
  assign loc_fast   = pins_sync[3];
  assign loc_permit = pins_sync[4];
  assign loc_clr    = pins_sync[5];

  assign remote_mode     = mode_reg[`DCSW_MB_REMOTE];
  assign bus_sel         = mode_reg[`DCSW_MB_BUS_SEL];
  assign remote_mode_out = remote_mode;

  // register writes; ramp and remote-request bits are stored but unused,
  // the controller is expected to hold them at one
  always @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      remote_control_word <= `DCSW_CTRL_RESET;
      mode_reg            <= `DCSW_MODE_RESET;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        `DCSW_ADDR_CTRL:
          remote_control_word <= reg_wdata_in;
        `DCSW_ADDR_MODE:
          mode_reg <= reg_wdata_in[1:0];
        default:
          remote_control_word <= remote_control_word; // unmapped: ignored
      endcase
    end
  end

  // register reads, data the cycle after the strobe
  always @(posedge clock_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= 16'h0000;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        `DCSW_ADDR_CTRL: reg_rdata_out <= remote_control_word;
        `DCSW_ADDR_STAT: reg_rdata_out <= remote_status_word;
        `DCSW_ADDR_MODE: reg_rdata_out <= {14'h0000, mode_reg};
        default:         reg_rdata_out <= 16'h0000; // unmapped reads zero
      endcase
    end
    else
      reg_rdata_out <= 16'h0000;
  end

  // sequencer command mapping, registered for clean outputs
  always @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      forward_run_request_out <= 1'b0;
      reverse_run_request_out <= 1'b0;
      stop_request_out        <= 1'b0;
      coast_release_out       <= 1'b0;
      fast_release_out        <= 1'b0;
      drive_enable_out        <= 1'b0;
      remote_fault_clear_out  <= 1'b0;
    end
    else if (remote_mode)
    begin
      // commands other than reverse and stop (held low) taken from the control word in remote mode; coast, fast and permit also gated by the local pins
      forward_run_request_out <= remote_control_word[`DCSW_CB_SWITCH_ON];
      reverse_run_request_out <= 1'b0;
      stop_request_out        <= 1'b0;
      coast_release_out <= remote_control_word[`DCSW_CB_NOT_COAST] & loc_coast;
      fast_release_out  <= remote_control_word[`DCSW_CB_NOT_FAST] & loc_fast;
      drive_enable_out  <= remote_control_word[`DCSW_CB_ENABLE_OP] & loc_permit;
      remote_fault_clear_out <= remote_control_word[`DCSW_CB_FAULT_CLR];
    end
    else
    begin
      // local terminal control
      forward_run_request_out <= loc_fwd;
      reverse_run_request_out <= loc_rev;
      stop_request_out        <= 1'b0;
      coast_release_out       <= loc_coast;
      fast_release_out        <= loc_fast;
      drive_enable_out        <= loc_permit;
      remote_fault_clear_out  <= loc_clr;
    end
  end

  // status views of the stop inputs depend on mode
  always @*
  begin
    if (remote_mode)
    begin
      view_coast = remote_control_word[`DCSW_CB_NOT_COAST];
      view_fast  = remote_control_word[`DCSW_CB_NOT_FAST];
    end
    else
    begin
      view_coast = loc_coast;
      view_fast  = loc_fast;
    end
  end

  // limit source chosen by control mode
  assign limit_hit = vector_mode_in ? torque_limit_in : current_limit_in;

  dcsw_status_build u_status (
    .clock_in     (clock_in),
    .sys_rst_in   (sys_rst_in),
    .permit_in    (seq_permit_in),
    .energised_in (seq_energised_in),
    .operating_in (seq_operating_in),
    .tripped_in   (seq_tripped_in),
    .not_coast_in (view_coast),
    .not_fast_in  (view_fast),
    .inhibited_in (seq_inhibited_in),
    .remote_ok_in (remote_mode & bus_sel),
    .ramping_in   (ramp_active_in),
    .limit_in     (limit_hit),
    .status_out   (remote_status_word)
  );
endmodule // dcsw_top
`default_nettype wire

// File: logic/dcsw_map.vh
`ifndef DCSW_MAP_VH
`define DCSW_MAP_VH
// register offsets
`define DCSW_ADDR_CTRL      4'h0
`define DCSW_ADDR_STAT      4'h1
`define DCSW_ADDR_MODE      4'h2
// control word field positions
`define DCSW_CB_SWITCH_ON   0
`define DCSW_CB_NOT_COAST   1
`define DCSW_CB_NOT_FAST    2
`define DCSW_CB_ENABLE_OP   3
`define DCSW_CB_FAULT_CLR   7
// status word field positions
`define DCSW_SB_PERMIT      0
`define DCSW_SB_ENERGISED   1
`define DCSW_SB_OPERATING   2
`define DCSW_SB_TRIPPED     3
`define DCSW_SB_NOT_COAST   4
`define DCSW_SB_NOT_FAST    5
`define DCSW_SB_INHIBIT     6
`define DCSW_SB_REMOTE      9
`define DCSW_SB_NOT_RAMPING 10
`define DCSW_SB_LIMIT       11
// mode register field positions
`define DCSW_MB_REMOTE      0
`define DCSW_MB_BUS_SEL     1
// reset values
`define DCSW_CTRL_RESET     16'h0000
`define DCSW_MODE_RESET     2'h0
// example command patterns
`define DCSW_CMD_RUN        16'h047F
`define DCSW_CMD_STOP       16'h047E
`endif

// File: logic/dcsw_sync2.v
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for a vector of pin levels
module dcsw_sync2 #(
  parameter WIDTH = 8
) (
  input  wire             clock_in,   // drive clock
  input  wire             sys_rst_in, // synchronous reset
  input  wire [WIDTH-1:0] async_in,   // raw pin levels
  output wire [WIDTH-1:0] sync_out    // levels safe to read
);
  reg [WIDTH-1:0] stage1; // read only by stage2
  reg [WIDTH-1:0] stage2; // synchronised copy

  // per-bit two-flop chain
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      always @(posedge clock_in)
      begin
        if (sys_rst_in)
        begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end
        else
        begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign sync_out = stage2;
endmodule // dcsw_sync2
`default_nettype wire

// File: logic/dcsw_status_build.v
`timescale 1ns/1ps
`default_nettype none
`include "dcsw_map.vh"
// registered status word assembly
module dcsw_status_build (
  input  wire        clock_in,        // drive clock
  input  wire        sys_rst_in,      // synchronous reset
  input  wire        permit_in,       // sequencer switch-on permitted
  input  wire        energised_in,    // sequencer switched on
  input  wire        operating_in,    // sequencer operating
  input  wire        tripped_in,      // sequencer tripped
  input  wire        not_coast_in,    // coast view chosen by mode
  input  wire        not_fast_in,     // fast view chosen by mode
  input  wire        inhibited_in,    // sequencer in start-inhibited state
  input  wire        remote_ok_in,    // remote and bus select
  input  wire        ramping_in,      // ramp generator moving
  input  wire        limit_in,        // internal limit active
  output reg  [15:0] status_out       // status word
);
  reg [15:0] next_status; // combinational word

  // assemble; unsupported bits stay zero
  always @*
  begin
    next_status = 16'h0000;
    next_status[`DCSW_SB_PERMIT]      = permit_in;
    next_status[`DCSW_SB_ENERGISED]   = energised_in;
    next_status[`DCSW_SB_OPERATING]   = operating_in;
    next_status[`DCSW_SB_TRIPPED]     = tripped_in;
    next_status[`DCSW_SB_NOT_COAST]   = not_coast_in;
    next_status[`DCSW_SB_NOT_FAST]    = not_fast_in;
    next_status[`DCSW_SB_INHIBIT]     = inhibited_in;
    next_status[`DCSW_SB_REMOTE]      = remote_ok_in;
    next_status[`DCSW_SB_NOT_RAMPING] = ~ramping_in;
    next_status[`DCSW_SB_LIMIT]       = limit_in;
  end

  // refreshed every clock so reads are never stale
  always @(posedge clock_in)
  begin
    if (sys_rst_in)
      status_out <= 16'h0000;
    else
      status_out <= next_status;
  end
endmodule // dcsw_status_build
`default_nettype wire

// File: dv/dcsw_props.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks of command mapping and status read-back
module dcsw_props (
  input wire logic        clock_in,
  input wire logic        sys_rst_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic        seq_permit_in,
  input wire logic        seq_energised_in,
  input wire logic        seq_operating_in,
  input wire logic        seq_tripped_in,
  input wire logic        seq_inhibited_in,
  input wire logic        ramp_active_in,
  input wire logic        vector_mode_in,
  input wire logic        torque_limit_in,
  input wire logic        current_limit_in,
  input wire logic        forward_run_request_out,
  input wire logic        reverse_run_request_out,
  input wire logic        stop_request_out,
  input wire logic        remote_fault_clear_out,
  input wire logic        remote_mode_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  wire       st_rd = reg_rd_in && reg_addr_in == 4'h1;  // status read
  wire       ct_wr = reg_wr_in && reg_addr_in == 4'h0;  // control write
  wire [3:0] seq4  = {seq_tripped_in, seq_operating_in, seq_energised_in, seq_permit_in};
  wire       lim   = vector_mode_in ? torque_limit_in : current_limit_in;  // limit by control mode
  // second step bars a mode write that would retarget the outputs
  fwd_follow_a: assert property ((ct_wr && remote_mode_out) ##1 !reg_wr_in |->
    ##1 forward_run_request_out == $past(reg_wdata_in[0], 2)) else $error("forward run wrong");
  fault_follow_a: assert property ((ct_wr && remote_mode_out) ##1 !reg_wr_in |->
    ##1 remote_fault_clear_out == $past(reg_wdata_in[7], 2)) else $error("fault clear wrong");
  rev_idle_a: assert property (remote_mode_out [*3] |-> !reverse_run_request_out)
    else $error("reverse run in remote");
  stop_idle_a: assert property (!stop_request_out) else $error("stop request raised");
  unsup_zero_a: assert property (st_rd |=> reg_rdata_out[15:12] == 4'h0 &&
    reg_rdata_out[8:7] == 2'h0) else $error("unsupported status bit set");
  seq_mirror_a: assert property (st_rd |=> reg_rdata_out[3:0] == $past(seq4, 2))
    else $error("sequencer mirror wrong");
  inhibit_bit_a: assert property (st_rd |=> reg_rdata_out[6] == $past(seq_inhibited_in, 2))
    else $error("inhibit bit wrong");
  ramp_bit_a: assert property (st_rd |=> reg_rdata_out[10] == !$past(ramp_active_in, 2))
    else $error("ramp bit wrong");
  limit_bit_a: assert property (st_rd |=> reg_rdata_out[11] == $past(lim, 2))
    else $error("limit bit wrong");
  cover property (st_rd);
  cover property (ct_wr && remote_mode_out);
  cover property (forward_run_request_out && remote_mode_out);
endmodule // dcsw_props
bind dcsw_top dcsw_props dcsw_props_inst (.*);
`default_nettype wire

// File: dv/dcsw_plc_model.sv
`timescale 1ns/1ps
`default_nettype none
// remote controller: one-cycle strobes, bus scrambled when idle
module dcsw_plc_model (
  input  wire logic   clock_in,
  output logic [3:0]  reg_addr_out,
  output logic [15:0] reg_wdata_out,
  output logic        reg_wr_out,
  output logic        reg_rd_out
);
  initial
  begin
    reg_addr_out = 4'h0;
    reg_wdata_out = 16'h0000;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  // inverted leftovers so a stale value can never pass as a match
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge clock_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge clock_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
  endtask
  // ramp and remote-request bits always sent as ones
  task automatic cmd(input logic [15:0] c);
    wr(4'h0, (c & 16'h008F) | 16'h0470);
  endtask
endmodule // dcsw_plc_model
`default_nettype wire

// File: dv/drive_control_status_words_test.sv
`timescale 1ns/1ps
`default_nettype none
module drive_control_status_words_test;
  logic        clock_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [5:0]  pins = 6'h00;   // fclr permit nfast ncoast rev fwd
  logic [8:0]  seq = 9'h000;   // cur tq vec ramp inh trip op ener permit
  logic [3:0]  a;
  logic [15:0] wd;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [6:0]  cmd_o;          // fwd rev stop coast fast enable fclr
  logic        remote;
  logic        rd_pend = 1'b0; // read answer due this edge
  logic [15:0] expq[$];
  logic [15:0] lw;
  int          mismatches = 0;
  int          cmp_count = 0;
  always #2.5 clock_in = ~clock_in;
  dcsw_plc_model dcsw_plc_model_inst (.clock_in(clock_in), .reg_addr_out(a),
    .reg_wdata_out(wd), .reg_wr_out(wr), .reg_rd_out(rd));
  dcsw_top dcsw_top_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_addr_in(a),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .local_forward_run_request_in(pins[0]), .local_reverse_run_request_in(pins[1]), .local_not_coast_n_in(pins[2]),
    .local_not_fast_n_in(pins[3]), .local_permit_in(pins[4]), .local_fault_clear_in(pins[5]),
    .seq_permit_in(seq[0]), .seq_energised_in(seq[1]), .seq_operating_in(seq[2]),
    .seq_tripped_in(seq[3]), .seq_inhibited_in(seq[4]), .ramp_active_in(seq[5]),
    .vector_mode_in(seq[6]), .torque_limit_in(seq[7]), .current_limit_in(seq[8]),
    .forward_run_request_out(cmd_o[6]), .reverse_run_request_out(cmd_o[5]),
    .stop_request_out(cmd_o[4]), .coast_release_out(cmd_o[3]), .fast_release_out(cmd_o[2]),
    .drive_enable_out(cmd_o[1]), .remote_fault_clear_out(cmd_o[0]), .remote_mode_out(remote));
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // read answers compared the cycle after the strobe
  always @(posedge clock_in)
  begin
    if (rd_pend)
      check("read data", expq.pop_front(), rdata);
    rd_pend <= rd;
  end
  task automatic rd_exp(input logic [3:0] ad, input logic [15:0] e);
    expq.push_back(e);
    dcsw_plc_model_inst.rd(ad);
  endtask
  function automatic logic [15:0] stat_exp(input logic [15:0] w, input logic rm, input logic sl);
    return {4'h0, seq[6] ? seq[7] : seq[8], !seq[5], rm & sl, 2'b00, seq[4],
            rm ? w[2] : pins[3], rm ? w[1] : pins[2], seq[3:0]};
  endfunction
  // one pass: pins, conditions, mode, command, then outputs and reads
  task automatic step(input logic rm, input logic sl, input logic [15:0] c);
    logic [6:0] e;
    lw = (c & 16'h008F) | 16'h0470;
    pins <= 6'($urandom);
    seq <= 9'($urandom);
    dcsw_plc_model_inst.wr(4'h2, {14'h0000, sl, rm});
    dcsw_plc_model_inst.cmd(c);
    repeat (4) @(posedge clock_in);
    e = rm ? {lw[0], 2'b00, lw[1] & pins[2], lw[2] & pins[3], lw[3] & pins[4], lw[7]}
           : {pins[0], pins[1], 1'b0, pins[2], pins[3], pins[4], pins[5]};
    check("commands", {9'h000, e}, {9'h000, cmd_o});
    check("remote mode", {15'h0000, rm}, {15'h0000, remote});
    rd_exp(4'h0, lw);
    rd_exp(4'h1, stat_exp(lw, rm, sl));
  endtask
  initial
  begin
    void'($urandom(62));
    repeat (3) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rd_exp(4'h2, 16'h0000);
    rd_exp(4'h0, 16'h0000);
    check("commands", 16'h0000, {9'h000, cmd_o});
    for (int i = 0; i < 40; i++)
      step(i[0], i[1], i == 1 ? 16'h047F : i == 5 ? 16'h047E : 16'($urandom));
    dcsw_plc_model_inst.wr(4'h1, 16'hFFFF);
    dcsw_plc_model_inst.wr(4'hF, 16'hFFFF);
    rd_exp(4'h0, lw);
    rd_exp(4'hF, 16'h0000);
    rd_exp(4'h1, stat_exp(lw, 1'b1, 1'b1));
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rd_exp(4'h0, 16'h0000);
    repeat (3) @(posedge clock_in);
    results();
  end
  // hang guard, far beyond the expected run length
  initial
  begin
    #50000;
    mismatches++;
    results();
  end
endmodule // drive_control_status_words_test
`default_nettype wire
